// File: logic/ssd_map.svh
// constants for the two-wire slave status decoder
`ifndef SSD_MAP_SVH
`define SSD_MAP_SVH
`define SSD_ST_SLV_RXDATA   4'h0
`define SSD_ST_STOP         4'h1
`define SSD_ST_ADDR         4'h2
`define SSD_ST_SLV_TXDATA   4'h4
`define SSD_ST_TX_BUSERR    4'h5
`define SSD_ST_MST_START    4'he
`define SSD_ST_IDLE         4'hf
`define SSD_OWN_ADDR        7'h2a
`define SSD_DIV_HALF        7'h3f
`define SSD_BIT_LAST        3'h7
`endif

// File: logic/ssd_pkg.sv
// types for the two-wire slave status decoder
package ssd_pkg;
    typedef enum logic [3:0]
    {
        SSD_IDLE    = 4'b0000,
        SSD_ADDR    = 4'b0001,
        SSD_RXBYTE  = 4'b0010,
        SSD_TXBYTE  = 4'b0011,
        SSD_ACKBIT  = 4'b0100,
        SSD_WAIT    = 4'b0101,
        SSD_DONE    = 4'b0110,
        SSD_ACKHOLD = 4'b0111,
        SSD_TXEND   = 4'b1000,
        SSD_TXACK   = 4'b1001
    } ssd_state_e;
endpackage

// File: logic/ssd_link_if.sv
// two-wire link between master end and slave device end
`timescale 1ns/100ps
`default_nettype none
interface ssd_link_if;
    logic scl;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic hold_n;
    logic frame;
    wire  sda_line = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
    modport master
    (
        output scl,
        output sda_m_o,
        output sda_m_oe,
        output frame,
        input  sda_line,
        input  hold_n
    );
    modport device
    (
        input  scl,
        input  frame,
        input  sda_line,
        output sda_s_o,
        output sda_s_oe,
        output hold_n
    );
endinterface
`default_nettype wire

// File: logic/ssd_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module ssd_sync
(
    input  wire logic i_clk,
    input  wire logic i_arst_n,
    input  wire logic i_d,
    output logic      o_q
);
    logic meta_ff;
    logic q_ff;
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            meta_ff <= 1'b0;
            q_ff    <= 1'b0;
        end
        else
        begin
            meta_ff <= i_d;
            q_ff    <= meta_ff;
        end
    end
    assign o_q = q_ff;
endmodule
`default_nettype wire

// File: logic/ssd_master.sv
// external master end: bit-serial driver on the system clock i_mclk
`timescale 1ns/100ps
`default_nettype none
`include "ssd_map.svh"
module ssd_master
(
    input  wire logic    i_mclk,
    input  wire logic    i_arst_n,
    input  wire logic    i_go,
    input  wire logic    i_rd,
    input  wire logic    i_nack_last,
    input  wire logic [7:0] i_wdata,
    output logic         o_busy,
    output logic [7:0]   o_rdata,
    output logic         o_rvalid,
    ssd_link_if.master   link
);
    // simple master: address, one data byte, stop
    logic [6:0] div_ff;
    logic       sda_s;
    logic       scl_ff;
    logic [5:0] step_ff;
    logic [8:0] sh_ff;
    logic       busy_ff;
    logic       rd_ff;
    logic [7:0] rdata_ff;
    logic       rvalid_ff;
    logic       hold_n_s;
    wire        tick = (div_ff == `SSD_DIV_HALF) && hold_n_s;
    wire        rise = tick && !scl_ff;
    ssd_sync u_hold
    (
        .i_clk    (i_mclk),
        .i_arst_n (i_arst_n),
        .i_d      (link.hold_n),
        .o_q      (hold_n_s)
    );
    ssd_sync u_sda
    (
        .i_clk    (i_mclk),
        .i_arst_n (i_arst_n),
        .i_d      (link.sda_line),
        .o_q      (sda_s)
    );
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            div_ff    <= 7'h00;
            scl_ff    <= 1'b1;
            step_ff   <= 6'h00;
            sh_ff     <= 9'h000;
            busy_ff   <= 1'b0;
            rd_ff     <= 1'b0;
            rdata_ff  <= 8'h00;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            rvalid_ff <= 1'b0;
            div_ff    <= tick ? 7'h00 : div_ff + 7'h01;
            if (!busy_ff && i_go)
            begin
                div_ff  <= 7'h00;
                busy_ff <= 1'b1;
                rd_ff   <= i_rd;
                sh_ff   <= {`SSD_OWN_ADDR, i_rd, 1'b1};
                step_ff <= 6'h00;
            end
            else if (busy_ff && tick)
            begin
                scl_ff <= !scl_ff;
                if (rise)
                begin
                    step_ff <= step_ff + 6'h01;
                    if (rd_ff && step_ff >= 6'h09 && step_ff < 6'h11)
                        rdata_ff <= {rdata_ff[6:0], sda_s};
                    if (step_ff == 6'h08)
                        sh_ff <= rd_ff ? {8'hff, i_nack_last}
                                       : {i_wdata, 1'b1};
                    else
                        sh_ff <= {sh_ff[7:0], 1'b1};
                    if (step_ff == 6'h12)
                    begin
                        busy_ff   <= 1'b0;
                        scl_ff    <= 1'b1;
                        rvalid_ff <= rd_ff;
                    end
                end
            end
        end
    end
    assign link.scl      = scl_ff;
    assign link.frame    = busy_ff;
    assign link.sda_m_o  = sh_ff[8];
    assign link.sda_m_oe = busy_ff && !sh_ff[8];
    assign o_busy        = busy_ff;
    assign o_rdata       = rdata_ff;
    assign o_rvalid      = rvalid_ff;
endmodule
`default_nettype wire

// File: logic/ssd_device.sv
// slave device end: status decoding with hardware acknowledge
`timescale 1ns/100ps
`default_nettype none
`include "ssd_map.svh"
module ssd_device
(
    input  wire logic       i_mclk,
    input  wire logic       i_arst_n,
    input  wire logic       i_link_clk,
    input  wire logic       i_hw_ack_gen_enable,
    input  wire logic       i_ack_bit,
    input  wire logic       i_start_request_bit,
    input  wire logic       i_stop_request_bit,
    input  wire logic       i_release,
    input  wire logic [7:0] i_twowire_data_reg,
    input  wire logic       i_mst_lost_rstart,
    input  wire logic       i_mst_lost_stop,
    input  wire logic       i_mst_lost_data,
    input  wire logic       i_mst_lost_addr,
    output logic [3:0]      o_status,
    output logic            o_ack_request_flag,
    output logic            o_arbitration_lost_flag,
    output logic            o_ack,
    output logic            o_pending,
    output logic [7:0]      o_rx_data,
    ssd_link_if.device      link
);
    logic [3:0] status_ff;
    logic       arbl_ff;
    logic       ackv_ff;
    logic       pend_ff;
    logic [7:0] rx_ff;
    logic       lost_ff;
    // link domain
    ssd_pkg::ssd_state_e st_ff;
    logic [2:0] bit_ff;
    logic [7:0] sh_ff;
    logic       rnw_ff;
    logic       addr_ph_ff;
    logic       ev_tgl_ff;
    logic [3:0] ev_code_ff;
    logic       ev_ack_ff;
    logic [7:0] ev_data_ff;
    logic       sda_o_ff;
    logic       sda_oe_ff;
    logic       scl_d_ff;
    logic       scl_l;
    logic       sda_l;
    logic       frame_l;
    logic       rel_s;
    logic       frame_s;
    logic       ev_s;
    logic       ev_d_ff;
    logic       rel_tgl_ff;
    logic       rel_seen_ff;
    wire        addr_hit = (sh_ff[7:1] == `SSD_OWN_ADDR);
    wire        scl_fall = scl_d_ff && !scl_l;
    wire        scl_rise = !scl_d_ff && scl_l;
    wire        rel_new  = (rel_s != rel_seen_ff);
    wire        ack_drv  = i_hw_ack_gen_enable
                           && (addr_ph_ff ? addr_hit : i_ack_bit);
    wire        ev_pulse = ev_s ^ ev_d_ff;
    wire        sw_resume = pend_ff && i_release;
    wire        mst_lost = i_mst_lost_rstart | i_mst_lost_stop
                           | i_mst_lost_data | i_mst_lost_addr;
    // link pins into the link domain
    ssd_sync u_scl
    (
        .i_clk    (i_link_clk),
        .i_arst_n (i_arst_n),
        .i_d      (link.scl),
        .o_q      (scl_l)
    );
    ssd_sync u_sda
    (
        .i_clk    (i_link_clk),
        .i_arst_n (i_arst_n),
        .i_d      (link.sda_line),
        .o_q      (sda_l)
    );
    ssd_sync u_fl
    (
        .i_clk    (i_link_clk),
        .i_arst_n (i_arst_n),
        .i_d      (link.frame),
        .o_q      (frame_l)
    );
    always_ff @(posedge i_link_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            st_ff      <= ssd_pkg::SSD_IDLE;
            bit_ff     <= 3'h0;
            sh_ff      <= 8'h00;
            rnw_ff     <= 1'b0;
            addr_ph_ff <= 1'b0;
            ev_tgl_ff  <= 1'b0;
            ev_code_ff <= 4'h0;
            ev_ack_ff  <= 1'b0;
            ev_data_ff <= 8'h00;
            sda_o_ff   <= 1'b1;
            sda_oe_ff  <= 1'b0;
            scl_d_ff   <= 1'b1;
            rel_seen_ff <= 1'b0;
        end
        else if (!frame_l)
        begin
            // frame over: free the line and rearm
            st_ff       <= ssd_pkg::SSD_IDLE;
            sda_oe_ff   <= 1'b0;
            scl_d_ff    <= scl_l;
            rel_seen_ff <= rel_s;
        end
        else
        begin
            scl_d_ff    <= scl_l;
            rel_seen_ff <= rel_s;
            case (st_ff)
                ssd_pkg::SSD_IDLE:
                begin
                    addr_ph_ff <= 1'b1;
                    bit_ff     <= 3'h0;
                    st_ff      <= ssd_pkg::SSD_ADDR;
                end
                ssd_pkg::SSD_ADDR, ssd_pkg::SSD_RXBYTE:
                begin
                    // sample while clock low, data stable
                    if (scl_fall)
                    begin
                        sh_ff  <= {sh_ff[6:0], sda_l};
                        bit_ff <= bit_ff + 3'h1;
                        if (bit_ff == `SSD_BIT_LAST)
                            st_ff <= ssd_pkg::SSD_ACKBIT;
                    end
                end
                ssd_pkg::SSD_ACKBIT:
                begin
                    if (scl_rise)
                    begin
                        sda_o_ff   <= 1'b0;
                        sda_oe_ff  <= ack_drv;
                        ev_data_ff <= sh_ff;
                        ev_ack_ff  <= i_ack_bit;
                        if (addr_ph_ff && !addr_hit)
                            st_ff <= ssd_pkg::SSD_DONE;
                        else
                        begin
                            ev_tgl_ff <= !ev_tgl_ff;
                            st_ff     <= ssd_pkg::SSD_WAIT;
                        end
                        if (addr_ph_ff)
                        begin
                            rnw_ff     <= sh_ff[0];
                            ev_code_ff <= `SSD_ST_ADDR;
                        end
                        else
                            ev_code_ff <= `SSD_ST_SLV_RXDATA;
                    end
                end
                ssd_pkg::SSD_WAIT:
                begin
                    // stretch until software releases
                    if (rel_new)
                    begin
                        addr_ph_ff <= 1'b0;
                        bit_ff     <= 3'h0;
                        sh_ff      <= i_twowire_data_reg;
                        if (!rnw_ff)
                            st_ff <= ssd_pkg::SSD_ACKHOLD;
                        else if (addr_ph_ff || ev_ack_ff)
                            st_ff <= ssd_pkg::SSD_TXBYTE;
                        else
                            st_ff <= ssd_pkg::SSD_DONE;
                    end
                end
                ssd_pkg::SSD_ACKHOLD:
                begin
                    if (scl_rise)
                    begin
                        sda_oe_ff <= 1'b0;
                        st_ff     <= ssd_pkg::SSD_RXBYTE;
                    end
                end
                ssd_pkg::SSD_TXBYTE:
                begin
                    if (scl_rise)
                    begin
                        sda_o_ff  <= sh_ff[7];
                        sda_oe_ff <= !sh_ff[7];
                        sh_ff     <= {sh_ff[6:0], 1'b1};
                        bit_ff    <= bit_ff + 3'h1;
                        if (bit_ff == `SSD_BIT_LAST)
                            st_ff <= ssd_pkg::SSD_TXEND;
                    end
                end
                ssd_pkg::SSD_TXEND:
                begin
                    if (scl_rise)
                    begin
                        sda_oe_ff <= 1'b0;
                        st_ff     <= ssd_pkg::SSD_TXACK;
                    end
                end
                ssd_pkg::SSD_TXACK:
                begin
                    if (scl_fall)
                    begin
                        ev_tgl_ff  <= !ev_tgl_ff;
                        ev_ack_ff  <= !sda_l;
                        ev_code_ff <= `SSD_ST_SLV_TXDATA;
                        st_ff      <= ssd_pkg::SSD_WAIT;
                    end
                end
                ssd_pkg::SSD_DONE:
                    sda_oe_ff <= 1'b0;
                default:
                    st_ff <= ssd_pkg::SSD_IDLE;
            endcase
        end
    end
    assign link.sda_s_o  = sda_o_ff;
    assign link.sda_s_oe = sda_oe_ff;
    assign link.hold_n   = !(st_ff == ssd_pkg::SSD_WAIT);
    // system clock domain, with the release toggle synchronised back onto the link clock
    ssd_sync u_ev
    (
        .i_clk    (i_mclk),
        .i_arst_n (i_arst_n),
        .i_d      (ev_tgl_ff),
        .o_q      (ev_s)
    );
    ssd_sync u_fr
    (
        .i_clk    (i_mclk),
        .i_arst_n (i_arst_n),
        .i_d      (link.frame),
        .o_q      (frame_s)
    );
    ssd_sync u_rel
    (
        .i_clk    (i_link_clk),
        .i_arst_n (i_arst_n),
        .i_d      (rel_tgl_ff),
        .o_q      (rel_s)
    );
    logic frame_d_ff;
    wire  stop_seen = frame_d_ff && !frame_s;
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            status_ff  <= `SSD_ST_IDLE;
            arbl_ff    <= 1'b0;
            ackv_ff    <= 1'b0;
            pend_ff    <= 1'b0;
            rx_ff      <= 8'h00;
            lost_ff    <= 1'b0;
            ev_d_ff    <= 1'b0;
            frame_d_ff <= 1'b0;
            rel_tgl_ff <= 1'b0;
        end
        else
        begin
            ev_d_ff    <= ev_s;
            frame_d_ff <= frame_s;
            if (sw_resume)
            begin
                pend_ff    <= 1'b0;
                rel_tgl_ff <= !rel_tgl_ff;
                if (i_start_request_bit)
                    status_ff <= `SSD_ST_MST_START;
            end
            if (ev_pulse)
            begin
                pend_ff   <= 1'b1;
                ackv_ff   <= ev_ack_ff;
                arbl_ff   <= lost_ff || mst_lost;
                status_ff <= ev_code_ff;
                if (ev_code_ff == `SSD_ST_SLV_RXDATA)
                    rx_ff <= ev_data_ff;
                lost_ff   <= 1'b0;
            end
            else if (mst_lost)
            begin
                if (i_mst_lost_addr)
                    lost_ff <= 1'b1;
                else
                begin
                    pend_ff <= 1'b1;
                    arbl_ff <= 1'b1;
                    if (i_mst_lost_rstart)
                        status_ff <= `SSD_ST_ADDR;
                    else if (i_mst_lost_stop)
                        status_ff <= `SSD_ST_STOP;
                    else
                        status_ff <= `SSD_ST_SLV_RXDATA;
                end
            end
            else if (stop_seen)
            begin
                pend_ff <= 1'b1;
                if (status_ff == `SSD_ST_SLV_TXDATA && !ackv_ff
                    && !arbl_ff)
                    status_ff <= `SSD_ST_STOP;
                else if (status_ff == `SSD_ST_SLV_TXDATA && ackv_ff)
                    status_ff <= `SSD_ST_TX_BUSERR;
                else
                    status_ff <= `SSD_ST_STOP;
                arbl_ff <= arbl_ff && status_ff == `SSD_ST_SLV_TXDATA;
                if (i_stop_request_bit)
                    pend_ff <= 1'b0;
            end
        end
    end
    assign o_status                = status_ff;
    assign o_ack_request_flag      = 1'b0;
    assign o_arbitration_lost_flag = arbl_ff;
    assign o_ack                   = ackv_ff;
    assign o_pending               = pend_ff;
    assign o_rx_data               = rx_ff;
endmodule
`default_nettype wire

// File: verif/ssd_link_chk.sv
// concurrent checks for the slave status decoder across the link
`timescale 1ns/100ps
`default_nettype none
module ssd_link_chk
(
    input  wire logic       i_mclk,
    input  wire logic       i_arst_n,
    input  wire logic       frame,
    input  wire logic       i_release,
    input  wire logic [3:0] o_status,
    input  wire logic       o_pending,
    input  wire logic       o_ack_request_flag,
    input  wire logic       o_arbitration_lost_flag
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_arst_n);
    // master ends the frame
    sequence frame_end_s;
        $fell(frame);
    endsequence
    // stop status posted for software
    sequence stop_posted_s;
        ##[1:60] (o_pending && o_status inside {4'h1, 4'h5});
    endsequence
    property stop_after_frame_p;
        frame_end_s |-> stop_posted_s;
    endproperty
    ack_request_flag_zero_a: assert property (!o_ack_request_flag)
        else $error("ack request flag not zero");
    stop_status_a: assert property (stop_after_frame_p)
        else $error("no stop status after frame end");
    pend_stands_a: assert property (
        o_pending && !i_release |=> o_pending)
        else $error("pending dropped without release");
    status_held_a: assert property (
        o_pending && !i_release |=> $stable(o_status))
        else $error("status moved while pending");
    pend_release_a: assert property (
        $fell(o_pending) |-> $past(i_release))
        else $error("pending fell without release");
    status_legal_a: assert property (
        o_status inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'he, 4'hf})
        else $error("status vector outside the table");
    status_posts_a: assert property (
        $changed(o_status) |-> o_pending || o_status == 4'he)
        else $error("status changed without pending");
    reset_value_a: assert property (
        $rose(i_arst_n) |-> o_status == 4'hf && !o_arbitration_lost_flag)
        else $error("status not idle after reset");
endmodule
`default_nettype wire

// File: verif/testbench.sv
// directed testbench for the master and slave ends of the link
`timescale 1ns/100ps
`default_nettype none
`include "ssd_map.svh"
module testbench;
    logic       i_mclk = 1'b0;
    logic       i_link_clk = 1'b0;
    logic       i_arst_n = 1'b0;
    logic       go = 1'b0;
    logic       rd = 1'b0;
    logic       nack = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] dreg = 8'h00;
    logic       i_release = 1'b0;
    logic       ack_bit = 1'b0;
    logic       start_request_bit = 1'b0;
    logic       stop_request_bit = 1'b0;
    logic       l_rs = 1'b0;
    logic       l_st = 1'b0;
    logic       l_dt = 1'b0;
    logic       l_ad = 1'b0;
    logic       o_busy;
    logic [7:0] o_rdata;
    logic [3:0] o_status;
    logic       o_ack_request_flag;
    logic       o_arbitration_lost_flag;
    logic       o_ack;
    logic       o_pending;
    logic [7:0] o_rx_data;
    int         num_errors = 0;
    int         n_tests = 0;
    int         cycles = 0;
    logic [3:0] lost_st [3] = '{`SSD_ST_ADDR, `SSD_ST_STOP,
                                `SSD_ST_SLV_RXDATA};
    ssd_link_if link ();
    ssd_master u_ssd_master
    (
        .i_mclk      (i_mclk),
        .i_arst_n    (i_arst_n),
        .i_go        (go),
        .i_rd        (rd),
        .i_nack_last (nack),
        .i_wdata     (wdata),
        .o_busy      (o_busy),
        .o_rdata     (o_rdata),
        .o_rvalid    (),
        .link        (link)
    );
    ssd_device u_ssd_device
    (
        .i_mclk                  (i_mclk),
        .i_arst_n                (i_arst_n),
        .i_link_clk              (i_link_clk),
        .i_hw_ack_gen_enable     (1'b1),
        .i_ack_bit               (ack_bit),
        .i_start_request_bit     (start_request_bit),
        .i_stop_request_bit      (stop_request_bit),
        .i_release               (i_release),
        .i_twowire_data_reg      (dreg),
        .i_mst_lost_rstart       (l_rs),
        .i_mst_lost_stop         (l_st),
        .i_mst_lost_data         (l_dt),
        .i_mst_lost_addr         (l_ad),
        .o_status                (o_status),
        .o_ack_request_flag      (o_ack_request_flag),
        .o_arbitration_lost_flag (o_arbitration_lost_flag),
        .o_ack                   (o_ack),
        .o_pending               (o_pending),
        .o_rx_data               (o_rx_data),
        .link                    (link)
    );
    ssd_link_chk u_chk
    (
        .i_mclk                  (i_mclk),
        .i_arst_n                (i_arst_n),
        .frame                   (link.frame),
        .i_release               (i_release),
        .o_status                (o_status),
        .o_pending               (o_pending),
        .o_ack_request_flag      (o_ack_request_flag),
        .o_arbitration_lost_flag (o_arbitration_lost_flag)
    );
    always #2.5 i_mclk = ~i_mclk;
    initial
    begin
        #1.3;
        forever #16 i_link_clk = ~i_link_clk;
    end
    task automatic close_out();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge i_mclk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            num_errors++;
            close_out();
        end
    end
    task automatic chk8(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e)
        begin
            num_errors++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic wait_pend();
        int n;
        n = 0;
        @(negedge i_mclk);
        while (o_pending !== 1'b1 && n < 4000)
        begin
            @(negedge i_mclk);
            n++;
        end
        chk1("pending", 1'b1, o_pending);
    endtask
    task automatic rel(input logic s, input logic a);
        @(posedge i_mclk);
        start_request_bit <= s;
        ack_bit <= a;
        i_release <= 1'b1;
        @(posedge i_mclk);
        i_release <= 1'b0;
    endtask
    task automatic do_reset();
        @(posedge i_mclk);
        i_arst_n <= 1'b0;
        repeat (3) @(posedge i_link_clk);
        @(posedge i_mclk);
        i_arst_n <= 1'b1;
        repeat (3) @(negedge i_link_clk);
        chk8("reset status", 8'h0f, {4'h0, o_status});
        chk1("reset arb lost", 1'b0, o_arbitration_lost_flag);
        chk1("ack request", 1'b0, o_ack_request_flag);
    endtask
    task automatic xfer(input logic r, input logic nk, input logic [7:0] d,
                        input logic la);
        int n;
        logic [3:0] es;
        es = (r && !nk) ? `SSD_ST_TX_BUSERR : `SSD_ST_STOP;
        @(posedge i_mclk);
        l_ad <= la;
        go <= 1'b1;
        rd <= r;
        nack <= nk;
        wdata <= d;
        dreg <= d;
        @(posedge i_mclk);
        go <= 1'b0;
        l_ad <= 1'b0;
        wait_pend();
        chk8("addr status", {4'h0, `SSD_ST_ADDR}, {4'h0, o_status});
        chk1("addr arb lost", la, o_arbitration_lost_flag);
        rel(1'b0, 1'b1);
        wait_pend();
        if (r)
        begin
            chk8("tx status", {4'h0, `SSD_ST_SLV_TXDATA}, {4'h0, o_status});
            chk1("tx ack", !nk, o_ack);
            rel(1'b0, 1'b0);
        end
        else
        begin
            chk8("rx status", {4'h0, `SSD_ST_SLV_RXDATA}, {4'h0, o_status});
            chk8("rx data", d, o_rx_data);
            rel(1'b0, 1'b1);
        end
        wait_pend();
        chk8("stop status", {4'h0, es}, {4'h0, o_status});
        chk1("stop arb lost", 1'b0, o_arbitration_lost_flag);
        rel(1'b0, 1'b0);
        n = 0;
        while (o_busy !== 1'b0 && n < 2000)
        begin
            @(negedge i_mclk);
            n++;
        end
        chk1("busy", 1'b0, o_busy);
        if (r)
            chk8("read data", d, o_rdata);
    endtask
    initial
    begin
        int n;
        do_reset();
        xfer(1'b0, 1'b0, 8'h5a, 1'b0);
        xfer(1'b0, 1'b0, 8'ha5, 1'b0);
        xfer(1'b1, 1'b1, 8'hc3, 1'b0);
        xfer(1'b1, 1'b0, 8'h96, 1'b0);
        xfer(1'b0, 1'b0, 8'h3c, 1'b1);
        for (int k = 0; k < 3; k++)
        begin
            @(posedge i_mclk);
            l_rs <= (k == 0);
            l_st <= (k == 1);
            l_dt <= (k == 2);
            @(posedge i_mclk);
            {l_rs, l_st, l_dt} <= 3'h0;
            wait_pend();
            chk8("lost status", {4'h0, lost_st[k]}, {4'h0, o_status});
            chk1("lost flag", 1'b1, o_arbitration_lost_flag);
            rel(k == 2, 1'b0);
        end
        n = 0;
        while (o_status !== `SSD_ST_MST_START && n < 1000)
        begin
            @(negedge i_mclk);
            n++;
        end
        chk8("retry status", 8'h0e, {4'h0, o_status});
        if (o_pending === 1'b1)
            rel(1'b0, 1'b0);
        start_request_bit <= 1'b0;
        do_reset();
        close_out();
    end
endmodule
`default_nettype wire
